// ==== src/mcsr_regs.sv ====
`timescale 1ns/1ps
module mcsr_regs import mcsr_pkg::*; #(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int CONV_MAX_CYCLES = CONV_MAX_CYC
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [9:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [9:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_mem_cmd,
  input wire logic i_mem_cmd_clear,
  input wire logic i_sec_tick,
  input wire logic i_min_tick,
  input wire logic i_rtc_alarm,
  input wire logic [7:0] i_rtc_min,
  input wire logic [7:0] i_rtc_hour,
  input wire logic [7:0] i_rtc_date,
  input wire logic [7:0] i_rtc_month,
  input wire logic [7:0] i_rtc_year,
  input wire logic i_force_conv,
  input wire logic i_conv_done,
  input wire logic [7:0] i_conv_result,
  input wire logic [7:0] i_low_thresh,
  input wire logic [7:0] i_high_thresh,
  output logic o_osc_run_n,
  output logic o_log_wrap,
  output logic o_search_hit,
  output logic o_mission_active,
  output logic o_sample_active,
  output logic o_conv_start,
  output logic o_clear_mem,
  output logic o_log_we,
  output logic [10:0] o_log_addr,
  output logic [7:0] o_log_data
);
  function automatic logic in_cfg_range(input logic [9:0] a);
    in_cfg_range = (a >= ADR_CFG_FIRST) && (a <= ADR_CFG_LAST);
  endfunction

  mcsr_state_t state_r;
  logic [7:0] ctrl_r;
  logic [7:0] srate_r;
  logic [15:0] start_dly_r;
  logic mem_cleared_r;
  logic mission_active_r;
  logic sample_active_r;
  logic conv_busy_r;
  logic low_flag_r;
  logic high_flag_r;
  logic timer_flag_r;
  logic osc_settled_r;
  logic first_conv_r;
  logic [7:0] ts_min_r;
  logic [7:0] ts_hour_r;
  logic [7:0] ts_date_r;
  logic [7:0] ts_month_r;
  logic [7:0] ts_year_r;
  logic [23:0] sample_cnt_r;
  logic [15:0] minutes_left_r;
  logic [10:0] log_idx_r;
  logic log_full_r;
  logic [7:0] status_rd;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_srate;
  logic do_clear;
  logic start_ok;
  logic end_mission;
  logic slot_due;
  logic wake_done;
  logic conv_timeout;
  logic mission_conv_done;
  logic force_ok;
  logic conv_go;

  assign wr_ctrl = i_wr_en && i_wr_addr == ADR_CTRL;
  assign wr_stat = i_wr_en && i_wr_addr == ADR_STAT;
  assign wr_srate = i_wr_en && i_wr_addr == ADR_SRATE;
  assign do_clear = i_mem_cmd && i_mem_cmd_clear && ctrl_r[CB_CLEAR_ARM]; // [RULE_05]
  // Start needs enable, cleared memory, a settled clock and a nonzero rate
  assign start_ok = wr_srate && i_wr_data != 8'h00 && !ctrl_r[CB_MISSION_EN_N] // [RULE_06] [RULE_17]
                    && mem_cleared_r && osc_settled_r && !mission_active_r; // [RULE_16] [RULE_04]
  assign end_mission = mission_active_r && ((i_wr_en && in_cfg_range(i_wr_addr)) // [RULE_18] [RULE_01]
                       || (wr_stat && !i_wr_data[SB_MISSION])); // [RULE_13]
  assign slot_due = i_min_tick && minutes_left_r == 16'h0000; // [RULE_19]
  assign mission_conv_done = state_r == ST_CONV && (i_conv_done || conv_timeout);
  assign force_ok = i_force_conv && !conv_busy_r && !sample_active_r;
  assign conv_go = (state_r == ST_WAKE && wake_done && !end_mission) || force_ok;

  mcsr_cycle_timer #(.CYCLES(WAKE_CYCLES)) u_wake_timer (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_start(state_r != ST_WAKE && state_r != ST_CONV && mission_active_r && !end_mission
             && slot_due && (state_r == ST_DELAY || state_r == ST_WAIT)),
    .i_abort(end_mission),
    .o_busy(),
    .o_done(wake_done)
  );

  // The watchdog bounds a sample even if the sensor never answers
  mcsr_cycle_timer #(.CYCLES(CONV_MAX_CYCLES)) u_conv_watchdog (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_start(!end_mission && slot_due && (state_r == ST_DELAY || state_r == ST_WAIT)),
    .i_abort(end_mission || mission_conv_done),
    .o_busy(),
    .o_done(conv_timeout)
  );

  // Control register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= i_wr_data & CTRL_WR_MASK; // [RULE_02] [RULE_01]
    end else if (i_mem_cmd) begin
      ctrl_r[CB_CLEAR_ARM] <= 1'b0; // [RULE_05]
    end
  end

  // Oscillator must tick one second before a mission may start
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      osc_settled_r <= 1'b0;
    end else if (ctrl_r[CB_OSC_RUN_N]) begin
      osc_settled_r <= 1'b0; // [RULE_03]
    end else if (i_sec_tick) begin
      osc_settled_r <= 1'b1; // [RULE_04]
    end
  end

  // Start delay and sample rate
  always_ff @(posedge i_mclk) begin
    if (i_srst || do_clear) begin
      start_dly_r <= 16'h0000; // [RULE_15]
      srate_r <= 8'h00;
    end else if (i_wr_en) begin
      if (i_wr_addr == ADR_DLY_LO) begin
        start_dly_r[7:0] <= i_wr_data; // [RULE_11]
      end
      if (i_wr_addr == ADR_DLY_HI) begin
        start_dly_r[15:8] <= i_wr_data; // [RULE_11]
      end
      if (i_wr_addr == ADR_SRATE) begin
        srate_r <= i_wr_data;
      end
    end
  end

  // Memory cleared flag
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mem_cleared_r <= 1'b0;
    end else if (do_clear) begin
      mem_cleared_r <= 1'b1; // [RULE_15]
    end else if (start_ok) begin
      mem_cleared_r <= 1'b0; // [RULE_16]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_clear_mem <= 1'b0;
    end else begin
      o_clear_mem <= do_clear; // [RULE_15]
    end
  end

  // Mission flag: only a valid sample-rate write (start_ok) sets it, other writes can only clear it
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mission_active_r <= 1'b0;
    end else if (start_ok) begin
      mission_active_r <= 1'b1; // [RULE_17]
    end else if (end_mission) begin
      mission_active_r <= 1'b0; // [RULE_18]
    end
  end

  // Mission sequencer
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_r <= ST_IDLE;
      minutes_left_r <= 16'h0000;
    end else if (end_mission) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_ok) begin
            state_r <= ST_DELAY;
            minutes_left_r <= start_dly_r; // [RULE_11]
          end
        end
        ST_DELAY, ST_WAIT: begin
          if (slot_due) begin
            state_r <= ST_WAKE; // [RULE_19]
          end else if (i_min_tick) begin
            minutes_left_r <= minutes_left_r - 16'h0001;
          end
        end
        ST_WAKE: begin
          if (wake_done) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (mission_conv_done) begin
            state_r <= ST_WAIT;
            minutes_left_r <= {8'h00, srate_r} - 16'h0001;
          end
        end
      endcase
    end
  end

  // Sample window: reads stay open, data may be stale meanwhile
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sample_active_r <= 1'b0;
    end else if (end_mission || mission_conv_done) begin
      sample_active_r <= 1'b0;
    end else if (slot_due && (state_r == ST_DELAY || state_r == ST_WAIT)) begin
      sample_active_r <= 1'b1; // [RULE_19] [RULE_20]
    end
  end

  // Conversion start and busy tracking
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_conv_start <= 1'b0;
      conv_busy_r <= 1'b0;
    end else begin
      o_conv_start <= conv_go;
      // Busy rises with the start pulse so the idle bit never reads 1 as a conversion begins
      if (conv_go) begin
        conv_busy_r <= 1'b1; // [RULE_14]
      end else if (i_conv_done || conv_timeout) begin
        conv_busy_r <= 1'b0; // [RULE_14]
      end
    end
  end

  // Timestamp of the first mission conversion
  always_ff @(posedge i_mclk) begin
    if (i_srst || do_clear) begin
      first_conv_r <= 1'b0;
      ts_min_r <= 8'h00;
      ts_hour_r <= 8'h00;
      ts_date_r <= 8'h00;
      ts_month_r <= 8'h00;
      ts_year_r <= 8'h00;
    end else if (start_ok) begin
      first_conv_r <= 1'b1;
    end else if (first_conv_r && state_r == ST_WAKE && wake_done) begin
      first_conv_r <= 1'b0;
      ts_min_r <= i_rtc_min; // [RULE_23]
      ts_hour_r <= i_rtc_hour;
      ts_date_r <= i_rtc_date;
      ts_month_r <= i_rtc_month;
      ts_year_r <= i_rtc_year;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst || do_clear) begin
      sample_cnt_r <= 24'h000000; // [RULE_24]
    end else if (mission_conv_done) begin
      sample_cnt_r <= sample_cnt_r + 24'h000001; // [RULE_24]
    end
  end

  // Data log write port
  always_ff @(posedge i_mclk) begin
    if (i_srst || start_ok) begin
      log_idx_r <= 11'h000;
      log_full_r <= 1'b0;
      o_log_we <= 1'b0;
      o_log_addr <= 11'h000;
      o_log_data <= 8'h00;
    end else if (mission_conv_done && (!log_full_r || ctrl_r[CB_LOG_WRAP])) begin
      o_log_we <= 1'b1; // [RULE_07]
      o_log_addr <= log_idx_r;
      o_log_data <= i_conv_result;
      log_idx_r <= log_idx_r + 11'h001;
      if (log_idx_r == LOG_LAST_IDX) begin
        log_full_r <= 1'b1;
      end
    end else begin
      o_log_we <= 1'b0;
    end
  end

  // Alarm flags: a hardware set beats a same-cycle clearing write
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      low_flag_r <= 1'b0;
      high_flag_r <= 1'b0;
      timer_flag_r <= 1'b0;
    end else begin
      if (mission_conv_done && i_conv_done && i_conv_result <= i_low_thresh) begin
        low_flag_r <= 1'b1; // [RULE_21]
      end else if (wr_stat && !i_wr_data[SB_LOW]) begin
        low_flag_r <= 1'b0; // [RULE_13]
      end
      if (mission_conv_done && i_conv_done && i_conv_result >= i_high_thresh) begin
        high_flag_r <= 1'b1; // [RULE_21]
      end else if (wr_stat && !i_wr_data[SB_HIGH]) begin
        high_flag_r <= 1'b0; // [RULE_13]
      end
      if (i_rtc_alarm) begin
        timer_flag_r <= 1'b1; // [RULE_22]
      end else if (wr_stat && !i_wr_data[SB_TIMER]) begin
        timer_flag_r <= 1'b0; // [RULE_22]
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_search_hit <= 1'b0;
    end else begin
      o_search_hit <= (ctrl_r[CB_LOW_SRCH] && low_flag_r) // [RULE_08]
                      || (ctrl_r[CB_HIGH_SRCH] && high_flag_r) // [RULE_09]
                      || (ctrl_r[CB_TIMER_SRCH] && timer_flag_r); // [RULE_10]
    end
  end

  // Bit 3 has no function and reads 0
  always_comb begin
    status_rd = 8'h00;
    status_rd[SB_CONV_IDLE_N] = !conv_busy_r; // [RULE_14]
    status_rd[SB_MEM_CLEARED] = mem_cleared_r;
    status_rd[SB_MISSION] = mission_active_r;
    status_rd[SB_SAMPLE] = sample_active_r;
    status_rd[SB_LOW] = low_flag_r;
    status_rd[SB_HIGH] = high_flag_r;
    status_rd[SB_TIMER] = timer_flag_r;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      unique case (i_rd_addr)
        ADR_SRATE: o_rd_data <= srate_r;
        ADR_CTRL: o_rd_data <= ctrl_r;
        ADR_DLY_LO: o_rd_data <= start_dly_r[7:0];
        ADR_DLY_HI: o_rd_data <= start_dly_r[15:8];
        ADR_STAT: o_rd_data <= status_rd;
        ADR_TS_MIN: o_rd_data <= ts_min_r;
        ADR_TS_HOUR: o_rd_data <= ts_hour_r;
        ADR_TS_DATE: o_rd_data <= ts_date_r;
        ADR_TS_MONTH: o_rd_data <= ts_month_r;
        ADR_TS_YEAR: o_rd_data <= ts_year_r;
        ADR_CNT_LO: o_rd_data <= sample_cnt_r[7:0];
        ADR_CNT_MID: o_rd_data <= sample_cnt_r[15:8];
        ADR_CNT_HI: o_rd_data <= sample_cnt_r[23:16];
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  assign o_osc_run_n = ctrl_r[CB_OSC_RUN_N]; // [RULE_03]
  assign o_log_wrap = ctrl_r[CB_LOG_WRAP];
  assign o_mission_active = mission_active_r;
  assign o_sample_active = sample_active_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  AST_CTRL_END_MISSION: assert property ( // [RULE_01]
    wr_ctrl && mission_active_r
    |=> !mission_active_r && ctrl_r == ($past(i_wr_data) & CTRL_WR_MASK))
    else $error("control write did not end mission");
  AST_BIT5_ZERO: assert property ( // [RULE_02]
    wr_ctrl |=> !ctrl_r[CB_UNUSED])
    else $error("control bit 5 not zero");
  AST_OSC_SETTLED: assert property ( // [RULE_04]
    $rose(mission_active_r) |-> $past(osc_settled_r) && !$past(ctrl_r[CB_OSC_RUN_N]))
    else $error("mission started before oscillator settled");
  AST_ARM_DROPS: assert property ( // [RULE_05]
    i_mem_cmd && !wr_ctrl |=> !ctrl_r[CB_CLEAR_ARM])
    else $error("clear arm not dropped");
  AST_NO_START_DISABLED: assert property ( // [RULE_06]
    ctrl_r[CB_MISSION_EN_N] && !mission_active_r |=> !mission_active_r)
    else $error("mission started while disabled");
  AST_CLEAR_EFFECT: assert property ( // [RULE_15]
    do_clear |=> mem_cleared_r && sample_cnt_r == 24'h000000 && srate_r == 8'h00 ##0 o_clear_mem)
    else $error("clear did not take effect");
  AST_START_NEEDS_CLEAR: assert property ( // [RULE_16]
    $rose(mission_active_r) |-> $past(mem_cleared_r) && !mem_cleared_r)
    else $error("mission started without cleared memory");
  AST_START: assert property ( // [RULE_17]
    start_ok |=> mission_active_r && state_r == ST_DELAY)
    else $error("valid sample-rate write did not start mission");
  AST_RANGE_END: assert property ( // [RULE_18]
    mission_active_r && i_wr_en && in_cfg_range(i_wr_addr)
    |=> !mission_active_r ##1 (!mission_active_r || $past(start_ok)))
    else $error("config write did not end mission");
  AST_STAT_NO_SET: assert property ( // [RULE_13]
    wr_stat && !mission_active_r |=> !mission_active_r)
    else $error("status write set mission flag");
  AST_CONV_IDLE: assert property ( // [RULE_14]
    o_conv_start |=> !status_rd[SB_CONV_IDLE_N])
    else $error("conv_idle_n not low after start");
  AST_SAMPLE_LEADS: assert property ( // [RULE_19]
    o_conv_start && !$past(force_ok) |-> sample_active_r)
    else $error("mission conversion without sample window");
  AST_TIMER_FLAG: assert property ( // [RULE_22]
    i_rtc_alarm |=> timer_flag_r)
    else $error("timer alarm flag not set");
  AST_COUNT_STEP: assert property ( // [RULE_24]
    mission_conv_done && !do_clear |=> sample_cnt_r == $past(sample_cnt_r) + 24'h000001)
    else $error("mission sample count did not step");

  COV_START: cover property (start_ok ##1 mission_active_r);
  COV_CLEAR: cover property (do_clear);
  COV_SAMPLE: cover property (mission_conv_done ##1 o_log_we);
  COV_END: cover property (end_mission);
endmodule

// ==== src/mcsr_pkg.sv ====
// What this block does
// RULE_01 - Writing the control register during a mission ends it and updates contents.
// RULE_02 - Control bit 5 always reads 0; writing 1 there has no effect.
// RULE_03 - Oscillator runs while osc_run_n is 0, stops when 1; host keeps it 0.
// RULE_04 - Mission start refused until the clock advanced one second since oscillator start.
// RULE_05 - Clear happens only if armed and next command; arm drops on next command.
// RULE_06 - mission_enable_n at 0 lets a sample-rate write start; at 1 nothing starts.
// RULE_07 - log_wrap 1 overwrites oldest samples; 0 stops logging when full, measuring continues.
// RULE_08 - Low-alarm search answers conditional search after a reading at or below threshold.
// RULE_09 - High-alarm search answers conditional search after a reading at or above threshold.
// RULE_10 - Timer-alarm search answers conditional search after a timer alarm; normally left 0.
// RULE_11 - Start delay is an unsigned 16-bit minute count, low byte at lower address.
// RULE_12 - Host programs staggered loggers with wrap disabled so full logs are kept.
// RULE_13 - Status: mission and alarm flags accept only 0 writes; others read-only, bit 3 unused.
// RULE_14 - conv_idle_n falls before any conversion, rises after the result is latched.
// RULE_15 - Clear zeroes upper pages, timestamp, count, delay and rate, then sets mem_cleared.
// RULE_16 - Mission starts only from cleared memory; mission start drops mem_cleared.
// RULE_17 - mission_active sets when enabled and a nonzero sample rate is written.
// RULE_18 - Any write to 200h-213h or a 0 written to the flag ends the mission.
// RULE_19 - Samples at minute rollover; sample_active leads conversion by 250ms, total within 875ms.
// RULE_20 - Reads of upper pages stay allowed during a sample but may be invalid.
// RULE_21 - Low and high flags set on threshold hits during a mission; host clears them.
// RULE_22 - Timer alarm flag sets on any clock alarm; a 0 write clears it anytime.
// RULE_23 - First conversion of a mission captures minute, hour, date, month and year.
// RULE_24 - Mission sample count is 24-bit, cleared only by the clear command.
package mcsr_pkg;
  localparam logic [9:0] ADR_CFG_FIRST = 10'h200;
  localparam logic [9:0] ADR_CFG_LAST = 10'h213;
  localparam logic [9:0] ADR_SRATE = 10'h20D;
  localparam logic [9:0] ADR_CTRL = 10'h20E;
  localparam logic [9:0] ADR_DLY_LO = 10'h212;
  localparam logic [9:0] ADR_DLY_HI = 10'h213;
  localparam logic [9:0] ADR_STAT = 10'h214;
  localparam logic [9:0] ADR_TS_MIN = 10'h215;
  localparam logic [9:0] ADR_TS_HOUR = 10'h216;
  localparam logic [9:0] ADR_TS_DATE = 10'h217;
  localparam logic [9:0] ADR_TS_MONTH = 10'h218;
  localparam logic [9:0] ADR_TS_YEAR = 10'h219;
  localparam logic [9:0] ADR_CNT_LO = 10'h21A;
  localparam logic [9:0] ADR_CNT_MID = 10'h21B;
  localparam logic [9:0] ADR_CNT_HI = 10'h21C;
  // Control bit positions
  localparam int CB_OSC_RUN_N = 7;
  localparam int CB_CLEAR_ARM = 6;
  localparam int CB_UNUSED = 5;
  localparam int CB_MISSION_EN_N = 4;
  localparam int CB_LOG_WRAP = 3;
  localparam int CB_LOW_SRCH = 2;
  localparam int CB_HIGH_SRCH = 1;
  localparam int CB_TIMER_SRCH = 0;
  // Status bit positions
  localparam int SB_CONV_IDLE_N = 7;
  localparam int SB_MEM_CLEARED = 6;
  localparam int SB_MISSION = 5;
  localparam int SB_SAMPLE = 4;
  localparam int SB_LOW = 2;
  localparam int SB_HIGH = 1;
  localparam int SB_TIMER = 0;
  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] CTRL_WR_MASK = 8'hDF;
  localparam logic [10:0] LOG_LAST_IDX = 11'h7FF;
  // Timing
  localparam int CLK_KHZ = 20000;
  localparam int WAKE_MS = 250;
  localparam int CONV_MAX_MS = 875;
  localparam int WAKE_CYC = WAKE_MS * CLK_KHZ;
  localparam int CONV_MAX_CYC = CONV_MAX_MS * CLK_KHZ;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_WAKE = 5'b01000,
    ST_CONV = 5'b10000
  } mcsr_state_t;
endpackage

// ==== src/mcsr_cycle_timer.sv ====
`timescale 1ns/1ps
module mcsr_cycle_timer #(
  parameter int CYCLES = 16
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic i_abort,
  output logic o_busy,
  output logic o_done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);
  logic [W-1:0] cnt_r;
  logic busy_r;

  always_ff @(posedge i_mclk) begin
    if (i_srst || i_abort) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      o_done <= 1'b0;
    end else if (i_start) begin
      busy_r <= 1'b1;
      cnt_r <= LOAD;
      o_done <= 1'b0;
    end else if (busy_r && cnt_r == '0) begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
    end else begin
      cnt_r <= busy_r ? cnt_r - W'(1) : cnt_r;
      o_done <= 1'b0;
    end
  end

  assign o_busy = busy_r;
endmodule

// ==== verification/mcsr_host_model.sv ====
`timescale 1ns/1ps
module mcsr_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [9:0] o_addr,
  output logic [7:0] o_data,
  output logic o_cmd,
  output logic o_cmd_clear
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 10'h000;
    o_data = 8'h00;
    o_cmd = 1'b0;
    o_cmd_clear = 1'b0;
  end
  // Idle address and data show the inverse so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_data = d;
    o_wr_en = 1'b1;
    @(negedge i_mclk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_data = ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_mclk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = i_rd_data;
  endtask
  // Clear is sent as the very next access after arming
  task automatic cmd(input logic clr);
    @(negedge i_mclk);
    o_cmd = 1'b1;
    o_cmd_clear = clr;
    @(negedge i_mclk);
    o_cmd = 1'b0;
    o_cmd_clear = ~clr;
  endtask
endmodule

// ==== verification/mission_control_status_regs_test.sv ====
`timescale 1ns/1ps
module mission_control_status_regs_test import mcsr_pkg::*;;
  logic i_mclk, i_srst, wr_en, rd_en, cmd, cmd_clr, srch, mact, sact, cst, clr, lwe, oscn, wrap;
  logic [9:0] addr;
  logic [7:0] wdata, rdata, res, ldata, rv;
  logic [10:0] laddr;
  logic [4:0] ev;
  logic [7:0] lo_t, hi_t;
  logic [39:0] rtc;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  mcsr_host_model host_i (.i_mclk(i_mclk), .i_rd_data(rdata), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_data(wdata), .o_cmd(cmd), .o_cmd_clear(cmd_clr));
  mcsr_regs #(.WAKE_CYCLES(8), .CONV_MAX_CYCLES(40)) mcsr_regs_i (.i_mclk(i_mclk),
    .i_srst(i_srst), .i_wr_en(wr_en), .i_wr_addr(addr), .i_wr_data(wdata), .i_rd_en(rd_en),
    .i_rd_addr(addr), .o_rd_data(rdata), .i_mem_cmd(cmd), .i_mem_cmd_clear(cmd_clr),
    .i_sec_tick(ev[0]), .i_min_tick(ev[1]), .i_rtc_alarm(ev[2]), .i_rtc_min(rtc[7:0]),
    .i_rtc_hour(rtc[15:8]), .i_rtc_date(rtc[23:16]), .i_rtc_month(rtc[31:24]),
    .i_rtc_year(rtc[39:32]), .i_force_conv(ev[4]), .i_conv_done(ev[3]), .i_conv_result(res),
    .i_low_thresh(lo_t), .i_high_thresh(hi_t), .o_osc_run_n(oscn), .o_log_wrap(wrap),
    .o_search_hit(srch), .o_mission_active(mact), .o_sample_active(sact), .o_conv_start(cst),
    .o_clear_mem(clr), .o_log_we(lwe), .o_log_addr(laddr), .o_log_data(ldata));
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    host_i.rd(a, rv);
    chk8($sformatf("reg %h", a), e, rv);
  endtask
  // One-cycle event: 0 second, 1 minute, 2 alarm, 3 conversion done, 4 forced conversion
  task automatic pulse(input int k);
    @(negedge i_mclk);
    ev = 5'h01 << k;
    @(negedge i_mclk);
    ev = 5'h00;
  endtask
  task automatic t_reset();
    rchk(ADR_STAT, 8'h80);
    rchk(ADR_CTRL, 8'h10);
  endtask
  task automatic t_ctrl();
    host_i.wr(ADR_CTRL, 8'hFF);
    rchk(ADR_CTRL, 8'hDF);
    chk1("osc_run_n", 1'b1, oscn);
    chk1("log_wrap", 1'b1, wrap);
  endtask
  task automatic t_clear();
    host_i.wr(ADR_DLY_LO, 8'h05);
    host_i.wr(ADR_CTRL, 8'h40);
    host_i.cmd(1'b0);
    chk1("clear_mem", 1'b0, clr);
    rchk(ADR_CTRL, 8'h00);
    host_i.wr(ADR_CTRL, 8'h40);
    host_i.cmd(1'b1);
    chk1("clear_mem", 1'b1, clr);
    rchk(ADR_STAT, 8'hC0);
    rchk(ADR_DLY_LO, 8'h00);
  endtask
  task automatic t_start();
    host_i.wr(ADR_CTRL, 8'h80);
    host_i.wr(ADR_CTRL, 8'h44); // Oscillator back on for normal use
    host_i.cmd(1'b1);
    host_i.wr(ADR_SRATE, 8'h01);
    chk1("mission refused", 1'b0, mact);
    host_i.wr(ADR_CTRL, 8'h14);
    pulse(0);
    host_i.wr(ADR_SRATE, 8'h01);
    chk1("mission refused", 1'b0, mact);
    // Wrap off as for staggered loggers, timer search off
    host_i.wr(ADR_CTRL, 8'h06);
    host_i.wr(ADR_DLY_LO, 8'h01);
    host_i.wr(ADR_DLY_HI, 8'h01);
    host_i.wr(ADR_SRATE, 8'h01);
    chk1("mission_active", 1'b1, mact);
    rchk(ADR_STAT, 8'hA0);
  endtask
  task automatic t_sample();
    repeat (257) pulse(1);
    chk1("sample_active", 1'b0, sact);
    pulse(1);
    chk1("sample_active", 1'b1, sact);
    repeat (10) @(negedge i_mclk);
    rchk(ADR_STAT, 8'h30);
    res = 8'h40;
    pulse(3);
    chk1("log_we", 1'b1, lwe);
    chk1("log_addr zero", 1'b1, laddr == 11'h000);
    rchk(ADR_STAT, 8'hA4);
    rchk(ADR_CNT_LO, 8'h01);
    rchk(ADR_TS_MIN, 8'h12);
    rchk(ADR_TS_YEAR, 8'h24);
    chk8("log_data", 8'h40, ldata);
    chk1("search_hit", 1'b1, srch);
    rtc[7:0] = 8'h13;
    pulse(1);
    repeat (10) @(negedge i_mclk);
    res = 8'hC0;
    pulse(3);
    rchk(ADR_STAT, 8'hA6);
    rchk(ADR_CNT_LO, 8'h02);
    rchk(ADR_TS_MIN, 8'h12);
    chk8("log_data", 8'hC0, ldata);
  endtask
  task automatic t_end();
    pulse(2);
    rchk(ADR_STAT, 8'hA7);
    host_i.wr(ADR_STAT, 8'h22);
    rchk(ADR_STAT, 8'hA2);
    chk1("search_hit", 1'b1, srch);
    host_i.wr(ADR_STAT, 8'h20);
    rchk(ADR_STAT, 8'hA0);
    chk1("search_hit", 1'b0, srch);
    host_i.wr(ADR_CTRL, 8'h04);
    chk1("mission_active", 1'b0, mact);
    host_i.wr(ADR_STAT, 8'h20);
    chk1("mission_active", 1'b0, mact);
    rchk(ADR_CNT_LO, 8'h02);
    host_i.wr(ADR_SRATE, 8'h02);
    chk1("mission refused", 1'b0, mact);
  endtask
  // Commanded conversion outside a mission: busy shows, no alarm flag is touched
  task automatic t_force();
    pulse(4);
    chk1("conv_start", 1'b1, cst);
    rchk(ADR_STAT, 8'h00);
    pulse(3);
    rchk(ADR_STAT, 8'h80);
  endtask
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run needs under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    i_srst = 1'b1;
    ev = 5'h00;
    res = 8'h80;
    lo_t = 8'h40;
    hi_t = 8'hC0;
    rtc = 40'h2406150812;
    repeat (16) @(negedge i_mclk);
    i_srst = 1'b0;
    t_reset();
    t_ctrl();
    t_clear();
    t_start();
    t_sample();
    t_end();
    t_force();
    wrap_up();
  end
endmodule
